//--- design/sdtc_pkg.sv
/*
 * sdtc_pkg: constants, field layouts and types for the segment descriptor type checker.
 * Assumes a 32-bit AHB-Lite register bus and the upper descriptor dword held as one register.
 */
package sdtc_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DESC_LO = 8'h04;
    localparam logic [7:0] OFS_DESC_HI = 8'h08;
    localparam logic [7:0] OFS_OFFSET = 8'h0C;
    localparam logic [7:0] OFS_CMD = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ------------------------------------------------------------
    // upper descriptor dword layout
    // ------------------------------------------------------------
    localparam int TYPE_LSB = 8;
    localparam int TYPE_W = 4;
    localparam int S_BIT = 12;
    localparam int DPL_LSB = 13;
    localparam int P_BIT = 15;
    localparam int LIM_HI_LSB = 16;
    localparam int LIM_HI_W = 4;
    localparam int LIM_LO_W = 16;
    localparam int B_BIT = 22;
    localparam int G_BIT = 23;
    localparam logic [31:0] ACC_MASK = 32'h0000_0100;
    // bit positions inside the type field
    localparam int TB_ACC = 0;
    localparam int TB_WR_RD = 1;
    localparam int TB_EC = 2;
    localparam int TB_CODE = 3;

    // ------------------------------------------------------------
    // limit arithmetic
    // ------------------------------------------------------------
    localparam logic [11:0] LIM_PAGE_FILL = 12'hFFF;
    localparam logic [11:0] LIM_BYTE_FILL = 12'h000;
    localparam logic [31:0] UPPER_BIG = 32'hFFFF_FFFF;
    localparam logic [31:0] UPPER_SMALL = 32'h0000_FFFF;

    // ------------------------------------------------------------
    // system type codes
    // ------------------------------------------------------------
    localparam logic [3:0] SYS_UPPER = 4'h0;
    localparam logic [3:0] SYS_TSS16_AVL = 4'h1;
    localparam logic [3:0] SYS_LDT = 4'h2;
    localparam logic [3:0] SYS_TSS16_BSY = 4'h3;
    localparam logic [3:0] SYS_CALL16 = 4'h4;
    localparam logic [3:0] SYS_TASK = 4'h5;
    localparam logic [3:0] SYS_INT16 = 4'h6;
    localparam logic [3:0] SYS_TRAP16 = 4'h7;
    localparam logic [3:0] SYS_TSS_AVL = 4'h9;
    localparam logic [3:0] SYS_TSS_BSY = 4'hB;
    localparam logic [3:0] SYS_CALL = 4'hC;
    localparam logic [3:0] SYS_INT = 4'hE;
    localparam logic [3:0] SYS_TRAP = 4'hF;
    localparam logic [1:0] GW_16 = 2'h0;
    localparam logic [1:0] GW_32 = 2'h1;
    localparam logic [1:0] GW_64 = 2'h2;
    localparam logic [1:0] CLS_DATA = 2'h0;
    localparam logic [1:0] CLS_CODE = 2'h1;
    localparam logic [1:0] CLS_SYS = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SK_NONE, SK_UPPER_HALF, SK_LDT, SK_TSS_AVAIL, SK_TSS_BUSY,
        SK_CALL_GATE, SK_INT_GATE, SK_TRAP_GATE, SK_TASK_GATE, SK_RESERVED
    } sdtc_sys_kind_t;

    typedef enum logic [2:0] {
        OP_LOAD_SS, OP_LOAD_DATA, OP_LOAD_SYS, OP_XFER_DIRECT, OP_XFER_GATE, OP_READ, OP_WRITE, OP_BAD
    } sdtc_op_t;

    typedef enum logic {ST_IDLE, ST_CHECK} sdtc_state_t;

    typedef struct packed {
        logic [26:0] rsvd;
        logic desc_mem_wr;
        logic prot;
        logic ext64;
        logic [1:0] cpl;
    } sdtc_ctrl_t;

    typedef struct packed {
        sdtc_sys_kind_t kind;
        logic reserved;
        logic sixteen_byte;
        logic code_ptr;
        logic tss_sel;
        logic [1:0] gate_width;
    } sdtc_sys_dec_t;

    typedef struct packed {
        logic [10:0] rsvd;
        logic [1:0] gate_width;
        sdtc_sys_kind_t kind;
        logic writable;
        logic readable;
        logic tss_sel;
        logic code_ptr;
        logic sys16;
        logic sys_rsvd;
        logic acc_set;
        logic [1:0] new_cpl;
        logic [1:0] cls;
        logic np;
        logic gp;
        logic done;
        logic busy;
    } sdtc_status_t;

endpackage

//--- design/sdtc_sys_decode.sv
/*
 * sdtc_sys_decode: registered decode of a system descriptor type code.
 * Assumes the type field and mode bits are stable for a cycle before the result is used.
 */
`timescale 1ns/1ps
module sdtc_sys_decode (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // descriptor and wide-mode bit
    input wire logic [3:0] type_code,
    input wire logic s_flag,
    input wire logic ext64,
    // result
    output sdtc_pkg::sdtc_sys_dec_t dec_reg
);
    import sdtc_pkg::*;

    sdtc_sys_dec_t dec_next;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    always_comb begin
        dec_next = '0;
        dec_next.kind = SK_RESERVED;
        dec_next.reserved = 1'b1;
        if (s_flag) begin
            dec_next = '0;
            dec_next.kind = SK_NONE;
        end else if (ext64) begin
            // RULE_17 wide-mode system types
            dec_next.sixteen_byte = 1'b1;
            dec_next.gate_width = GW_64;
            dec_next.reserved = 1'b0;
            case (type_code)
                SYS_UPPER: dec_next.kind = SK_UPPER_HALF;
                SYS_LDT: dec_next.kind = SK_LDT;
                SYS_TSS_AVL: dec_next.kind = SK_TSS_AVAIL;
                SYS_TSS_BSY: dec_next.kind = SK_TSS_BUSY;
                SYS_CALL: dec_next.kind = SK_CALL_GATE;
                SYS_INT: dec_next.kind = SK_INT_GATE;
                SYS_TRAP: dec_next.kind = SK_TRAP_GATE;
                default: begin
                    dec_next.kind = SK_RESERVED;
                    dec_next.reserved = 1'b1;
                end
            endcase
        end else begin
            // RULE_15 RULE_16 legacy system types
            dec_next.reserved = 1'b0;
            dec_next.gate_width = type_code[TB_CODE] ? GW_32 : GW_16;
            case (type_code)
                SYS_TSS16_AVL, SYS_TSS_AVL: dec_next.kind = SK_TSS_AVAIL;
                SYS_TSS16_BSY, SYS_TSS_BSY: dec_next.kind = SK_TSS_BUSY;
                SYS_LDT: dec_next.kind = SK_LDT;
                SYS_CALL16, SYS_CALL: dec_next.kind = SK_CALL_GATE;
                SYS_INT16, SYS_INT: dec_next.kind = SK_INT_GATE;
                SYS_TRAP16, SYS_TRAP: dec_next.kind = SK_TRAP_GATE;
                SYS_TASK: dec_next.kind = SK_TASK_GATE;
                default: begin
                    dec_next.kind = SK_RESERVED;
                    dec_next.reserved = 1'b1;
                end
            endcase
        end
        // RULE_18 what a gate points at
        dec_next.code_ptr = (dec_next.kind == SK_CALL_GATE) || (dec_next.kind == SK_INT_GATE) ||
                            (dec_next.kind == SK_TRAP_GATE);
        dec_next.tss_sel = (dec_next.kind == SK_TASK_GATE);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dec_reg <= '0;
        end else begin
            dec_reg <= dec_next;
        end
    end

endmodule // sdtc_sys_decode

//--- design/sdtc_top.sv
/*
 * sdtc_top: segment descriptor type checker with an AHB-Lite register slave.
 * Assumes a single AHB-Lite master issuing whole-word single transfers; zero wait states.
 */
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
// Overview of operation
// RULE_01: descriptor flag set means application type; type bit 11 picks data or code.
// RULE_02: data type bits 8,9,10 are accessed, write-enable, expand-down.
// RULE_03: data write-enable clear is read-only, set is read/write.
// RULE_04: loading the stack register with non-writable data raises protection fault.
// RULE_05: successful loads set accessed bit when descriptor memory is writable; stays set.
// RULE_06: code type bits 8,9,10 are accessed, read-enable, conforming.
// RULE_07: code read-enable clear is execute-only, set is execute/read.
// RULE_08: execute/read code may be read as data.
// RULE_09: in protected mode writes to code always fault.
// RULE_10: entering more-privileged conforming code keeps the current privilege level.
// RULE_11: direct transfer to nonconforming code at another level faults unless gated.
// RULE_12: calls or jumps into less-privileged code always fault.
// RULE_13: data is nonconforming: less-privileged access faults, more-privileged access allowed.
// RULE_14: software should pre-set accessed bits in descriptors held in read-only memory.
// RULE_15: descriptor flag clear means system descriptor: table, task state or gate.
// RULE_16: legacy mode system type codes decoded, with codes 0, 8, 10, 13 reserved.
// RULE_17: wide mode system descriptors are 16 bytes with their own type codes.
// RULE_18: call, interrupt, trap gates hold code pointers; task gates hold task selectors.
// RULE_19: expand-up segments fault when offset exceeds the limit.
// RULE_20: expand-down segments fault below the limit; big flag picks the upper bound.
// RULE_21: loading a descriptor whose present flag is clear raises not-present fault.
// RULE_22: reserved system type codes raise protection fault.
module sdtc_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp
);
    import sdtc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_addr_reg, wr_addr_next;
    logic [31:0] hrdata_next;
    sdtc_ctrl_t ctrl_reg, ctrl_next;
    logic [31:0] desc_lo_reg, desc_lo_next;
    logic [31:0] desc_hi_reg, desc_hi_next;
    logic [31:0] offset_reg, offset_next;
    sdtc_op_t op_reg, op_next;
    sdtc_status_t status_reg, status_next;
    sdtc_state_t state_reg, state_next;
    sdtc_sys_dec_t sys_dec;

    // ------------------------------------------------------------
    // descriptor fields
    // ------------------------------------------------------------
    logic [3:0] ty;
    logic is_app, is_code, is_data, dat_wr, expand_dn, code_rd, conforming, present;
    logic [1:0] dpl, cpl;
    logic [19:0] lim20;
    logic [31:0] eff_lim, upper;
    logic lim_fault, is_load, in_chk;
    logic gp_next, np_next, acc_set;
    logic [1:0] new_cpl;
    logic addr_ok, wr_hit;

    assign ty = desc_hi_reg[TYPE_LSB +: TYPE_W];
    assign is_app = desc_hi_reg[S_BIT];
    // RULE_01 data or code selection
    assign is_code = is_app & ty[TB_CODE];
    assign is_data = is_app & ~ty[TB_CODE];
    // RULE_02 RULE_03 data flags
    assign dat_wr = is_data & ty[TB_WR_RD];
    assign expand_dn = is_data & ty[TB_EC];
    // RULE_06 RULE_07 code flags
    assign code_rd = is_code & ty[TB_WR_RD];
    assign conforming = is_code & ty[TB_EC];
    assign present = desc_hi_reg[P_BIT];
    assign dpl = desc_hi_reg[DPL_LSB +: 2];
    assign cpl = ctrl_reg.cpl;
    assign lim20 = {desc_hi_reg[LIM_HI_LSB +: LIM_HI_W], desc_lo_reg[LIM_LO_W-1:0]};
    assign eff_lim = desc_hi_reg[G_BIT] ? {lim20, LIM_PAGE_FILL} : {LIM_BYTE_FILL, lim20};
    assign upper = desc_hi_reg[B_BIT] ? UPPER_BIG : UPPER_SMALL;
    // RULE_19 RULE_20 limit test
    assign lim_fault = expand_dn ? ((offset_reg < eff_lim) || (offset_reg > upper)) : (offset_reg > eff_lim);
    assign is_load = (op_reg != OP_READ) && (op_reg != OP_WRITE);
    assign in_chk = (state_reg == ST_CHECK);

    sdtc_sys_decode u_sys_decode (
        .hclk(hclk),
        .hresetn(hresetn),
        .type_code(ty),
        .s_flag(is_app),
        .ext64(ctrl_reg.ext64),
        .dec_reg(sys_dec)
    );

    // ------------------------------------------------------------
    // protection checks
    // ------------------------------------------------------------
    always_comb begin
        gp_next = 1'b0;
        new_cpl = cpl;
        case (op_reg)
            // RULE_04 stack must be writable data
            OP_LOAD_SS: gp_next = !dat_wr || (cpl > dpl);
            // RULE_08 readable code may sit in a data register
            OP_LOAD_DATA: gp_next = !is_app || (is_code && !code_rd) || (is_data && (cpl > dpl));
            // RULE_22 reserved system types refused
            OP_LOAD_SYS: gp_next = is_app || sys_dec.reserved;
            // RULE_11 RULE_12 direct transfers
            OP_XFER_DIRECT: gp_next = !is_code || (conforming ? (dpl > cpl) : (dpl != cpl));
            OP_XFER_GATE: begin
                gp_next = !is_code || (dpl > cpl);
                // RULE_10 conforming keeps level
                new_cpl = conforming ? cpl : dpl;
            end
            // RULE_13 data privilege
            OP_READ: gp_next = !is_app || (is_code && !code_rd) || (is_data && (cpl > dpl)) || lim_fault;
            // RULE_09 code never written in protected mode
            OP_WRITE: gp_next = !is_app || (is_code && ctrl_reg.prot) || (is_data && (!dat_wr || (cpl > dpl))) ||
                                lim_fault;
            default: gp_next = 1'b1;
        endcase
        // RULE_22 reserved code on any system reference
        if (!is_app && sys_dec.reserved) begin
            gp_next = 1'b1;
        end
        // RULE_21 present checked after type
        np_next = is_load && !present && !gp_next;
        // RULE_05 only writable descriptor memory is updated
        acc_set = in_chk && is_load && is_app && !gp_next && !np_next && ctrl_reg.desc_mem_wr;
    end

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    assign addr_ok = hsel && hready && htrans[1];

    always_comb begin
        wr_pend_next = addr_ok && hwrite && (hsize == HSIZE_WORD);
        wr_addr_next = addr_ok ? haddr[7:0] : wr_addr_reg;
        hrdata_next = '0;
        if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                OFS_CTRL: hrdata_next = ctrl_reg;
                OFS_DESC_LO: hrdata_next = desc_lo_reg;
                OFS_DESC_HI: hrdata_next = desc_hi_reg;
                OFS_OFFSET: hrdata_next = offset_reg;
                OFS_CMD: hrdata_next = {29'h0000_0000, op_reg};
                OFS_STATUS: hrdata_next = status_reg;
                default: hrdata_next = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers and sequencer
    // ------------------------------------------------------------
    always_comb begin
        wr_hit = 1'b0;
        ctrl_next = ctrl_reg;
        desc_lo_next = desc_lo_reg;
        desc_hi_next = desc_hi_reg;
        offset_next = offset_reg;
        op_next = op_reg;
        state_next = state_reg;
        status_next = status_reg;
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                OFS_CTRL: begin
                    ctrl_next = hwdata;
                    ctrl_next.rsvd = '0;
                end
                OFS_DESC_LO: desc_lo_next = hwdata;
                OFS_DESC_HI: desc_hi_next = hwdata;
                OFS_OFFSET: offset_next = hwdata;
                OFS_CMD: wr_hit = (state_reg == ST_IDLE);
                default: wr_hit = 1'b0;
            endcase
        end
        // RULE_05 set beats a same-cycle software clear
        if (acc_set) begin
            desc_hi_next = desc_hi_next | ACC_MASK;
        end
        case (state_reg)
            ST_IDLE: begin
                if (wr_hit) begin
                    // commands while busy are dropped; the check takes one cycle
                    op_next = sdtc_op_t'(hwdata[2:0]);
                    status_next = '0;
                    status_next.busy = 1'b1;
                    state_next = ST_CHECK;
                end
            end
            ST_CHECK: begin
                status_next = '0;
                status_next.done = 1'b1;
                status_next.gp = gp_next;
                status_next.np = np_next;
                status_next.new_cpl = new_cpl;
                status_next.cls = !is_app ? CLS_SYS : (is_code ? CLS_CODE : CLS_DATA);
                status_next.acc_set = acc_set;
                status_next.sys_rsvd = sys_dec.reserved;
                status_next.sys16 = sys_dec.sixteen_byte;
                status_next.code_ptr = sys_dec.code_ptr;
                status_next.tss_sel = sys_dec.tss_sel;
                status_next.readable = is_data || code_rd;
                status_next.writable = dat_wr;
                status_next.kind = sys_dec.kind;
                status_next.gate_width = sys_dec.gate_width;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            hrdata <= '0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            ctrl_reg <= '0;
            desc_lo_reg <= '0;
            desc_hi_reg <= '0;
            offset_reg <= '0;
            op_reg <= OP_LOAD_SS;
            status_reg <= '0;
            state_reg <= ST_IDLE;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            hrdata <= hrdata_next;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            ctrl_reg <= ctrl_next;
            desc_lo_reg <= desc_lo_next;
            desc_hi_reg <= desc_hi_next;
            offset_reg <= offset_next;
            op_reg <= op_next;
            status_reg <= status_next;
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_ss_nonwritable;
        @(posedge hclk) disable iff (!hresetn) in_chk && (op_reg == OP_LOAD_SS) && !dat_wr |=> status_reg.gp;
    endproperty
    a_ss_nonwritable: assert property (p_ss_nonwritable) else $error("stack load of non-writable data passed"); // RULE_04

    property p_acc_set;
        @(posedge hclk) disable iff (!hresetn)
            in_chk && is_load && is_app && !gp_next && !np_next && ctrl_reg.desc_mem_wr
            |=> desc_hi_reg[TYPE_LSB + TB_ACC] && status_reg.acc_set;
    endproperty
    a_acc_set: assert property (p_acc_set) else $error("accessed bit not set on load"); // RULE_05

    property p_acc_rom;
        @(posedge hclk) disable iff (!hresetn) in_chk && !ctrl_reg.desc_mem_wr |=> !status_reg.acc_set;
    endproperty
    a_acc_rom: assert property (p_acc_rom) else $error("accessed bit written to read-only memory"); // RULE_05

    property p_code_write;
        @(posedge hclk) disable iff (!hresetn)
            in_chk && (op_reg == OP_WRITE) && is_code && ctrl_reg.prot |=> status_reg.gp && status_reg.done;
    endproperty
    a_code_write: assert property (p_code_write) else $error("write to code segment allowed"); // RULE_09

    property p_conf_cpl;
        @(posedge hclk) disable iff (!hresetn)
            in_chk && (op_reg == OP_XFER_GATE) && conforming |=> status_reg.new_cpl == $past(ctrl_reg.cpl);
    endproperty
    a_conf_cpl: assert property (p_conf_cpl) else $error("conforming entry changed level"); // RULE_10

    property p_nonconf;
        @(posedge hclk) disable iff (!hresetn)
            in_chk && (op_reg == OP_XFER_DIRECT) && is_code && !conforming && (dpl != cpl) |=> status_reg.gp;
    endproperty
    a_nonconf: assert property (p_nonconf) else $error("direct nonconforming transfer allowed"); // RULE_11

    property p_less_priv;
        @(posedge hclk) disable iff (!hresetn)
            in_chk && ((op_reg == OP_XFER_DIRECT) || (op_reg == OP_XFER_GATE)) && (dpl > cpl) |=> status_reg.gp;
    endproperty
    a_less_priv: assert property (p_less_priv) else $error("transfer to less privileged code allowed"); // RULE_12

    property p_data_priv;
        @(posedge hclk) disable iff (!hresetn)
            in_chk && (op_reg == OP_READ) && is_data && (cpl > dpl) |=> status_reg.gp;
    endproperty
    a_data_priv: assert property (p_data_priv) else $error("less privileged data read allowed"); // RULE_13

    property p_not_present;
        @(posedge hclk) disable iff (!hresetn)
            in_chk && (op_reg == OP_LOAD_DATA) && is_data && (cpl <= dpl) && !present |=> status_reg.np && !status_reg.gp;
    endproperty
    a_not_present: assert property (p_not_present) else $error("absent segment loaded"); // RULE_21

    property p_sys_rsvd;
        @(posedge hclk) disable iff (!hresetn) in_chk && !is_app && sys_dec.reserved |=> status_reg.gp;
    endproperty
    a_sys_rsvd: assert property (p_sys_rsvd) else $error("reserved system type accepted"); // RULE_22

    property p_cmd_flow;
        @(posedge hclk) disable iff (!hresetn)
            (state_reg == ST_IDLE) && wr_pend_reg && (wr_addr_reg == OFS_CMD) |=> status_reg.busy ##1 status_reg.done;
    endproperty
    a_cmd_flow: assert property (p_cmd_flow) else $error("command did not complete in two cycles");

    c_gate_raise: cover property (@(posedge hclk) disable iff (!hresetn)
        in_chk && (op_reg == OP_XFER_GATE) && !conforming && (dpl < cpl) && present);
    c_np: cover property (@(posedge hclk) disable iff (!hresetn) in_chk ##1 status_reg.np);
    c_expand_dn: cover property (@(posedge hclk) disable iff (!hresetn) in_chk && expand_dn && lim_fault);
    c_ss_ok: cover property (@(posedge hclk) disable iff (!hresetn) in_chk && (op_reg == OP_LOAD_SS) && acc_set);

endmodule // sdtc_top

//--- verif/sdtc_desc_table.sv
/* sdtc_desc_table: small model of descriptor memory beside the checker.
   Assumes entry 0 sits in writable memory and entry 1 in read-only memory. */
`timescale 1ns/1ps
module sdtc_desc_table (
    // lookup
    input wire logic idx,
    // descriptor upper dword and read-only memory flag
    output logic [31:0] desc_hi,
    output logic in_rom
);
    // ----------
    // table
    // ----------
    always_comb begin
        in_rom = idx;
        // accessed preset, since rom cannot take the update
        desc_hi = idx ? 32'h0000_9300 : 32'h0000_9200;
    end
endmodule // sdtc_desc_table

//--- verif/tb_sdtc_top.sv
/* tb_sdtc_top: self-checking bench for the descriptor type checker.
   Assumes a zero-wait slave; hready is looped back from hreadyout. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_sdtc_top;
    import sdtc_pkg::*;
    typedef struct {logic [4:0] c; logic [15:0] h; logic [2:0] op; logic o; logic [7:0] e; logic [7:0] m;} sdtc_row_t;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, idx = 1'b0, hreadyout, hresp, in_rom;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, mem_hi, st;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    int err_total = 0;
    int total_checks = 0;
    // rows: ctrl, desc_hi, op, offset, expected status[7:0], mask
    sdtc_row_t rows [17] = '{
        '{5'h00,16'h9000,3'h0,1'b0,8'h06,8'h3E}, '{5'h00,16'h9200,3'h0,1'b0,8'h02,8'h3E},
        '{5'h00,16'h9800,3'h1,1'b0,8'h16,8'h3E}, '{5'h00,16'h9A00,3'h1,1'b0,8'h12,8'h3E},
        '{5'h08,16'h9A00,3'h6,1'b0,8'h16,8'h3E}, '{5'h00,16'hBA00,3'h3,1'b0,8'h16,8'h3E},
        '{5'h02,16'h9A00,3'h4,1'b0,8'h12,8'hFE}, '{5'h03,16'h9E00,3'h4,1'b0,8'hD2,8'hFE},
        '{5'h00,16'hFE00,3'h3,1'b0,8'h16,8'h3E}, '{5'h03,16'h9200,3'h1,1'b0,8'h06,8'h3E},
        '{5'h00,16'h1200,3'h1,1'b0,8'h0A,8'h3E}, '{5'h00,16'h9200,3'h5,1'b1,8'h06,8'h3E},
        '{5'h00,16'h9600,3'h5,1'b1,8'h02,8'h3E}, '{5'h00,16'h8800,3'h2,1'b0,8'h26,8'h3E},
        '{5'h04,16'h8100,3'h2,1'b0,8'h26,8'h3E}, '{5'h00,16'h9200,3'h7,1'b0,8'h06,8'h06},
        '{5'h03,16'h9200,3'h5,1'b0,8'h06,8'h3E}};
    sdtc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
    sdtc_desc_table mem (.idx(idx), .desc_hi(mem_hi), .in_rom(in_rom));
    initial begin
        forever #4 hclk = ~hclk;
    end
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // bounded wait, so a stuck slave ends the run instead of hanging it
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_total++;
                test_done();
            end
            @(posedge hclk);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask
    task automatic run(input logic [4:0] c, input logic [15:0] h, input logic [2:0] op, input logic o);
        bus(1'b1, OFS_CTRL, {27'h0, c}, st);
        bus(1'b1, OFS_DESC_HI, {16'h0, h}, st);
        bus(1'b1, OFS_OFFSET, {31'h0, o}, st);
        bus(1'b1, OFS_CMD, {29'h0, op}, st);
        // status is fetched in the address phase, so the first read may still show busy
        bus(1'b0, OFS_STATUS, 32'h0, st);
        for (int n = 0; n < 8 && st[1] !== 1'b1; n++) begin
            bus(1'b0, OFS_STATUS, 32'h0, st);
        end
        if (st[1] !== 1'b1) begin
            err_total++;
            test_done();
        end
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        `CHK("rst_ready", 1'b0, hreadyout)
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        foreach (rows[i]) begin
            run(rows[i].c, rows[i].h, rows[i].op, rows[i].o);
            `CHK($sformatf("row%0d", i), rows[i].e, st[7:0] & rows[i].m)
        end
        run(5'h00, 16'h8C00, 3'h2, 1'b0);
        `CHK("call_gate", 8'h55, {st[20:15], st[12:11]})
        run(5'h00, 16'h8500, 3'h2, 1'b0);
        `CHK("task_gate", 6'h22, {st[18:15], st[12:11]})
        for (int i = 0; i < 2; i++) begin
            idx = i[0];
            @(posedge hclk);
            run({~in_rom, 4'h0}, mem_hi[15:0], 3'h1, 1'b0);
            bus(1'b0, OFS_DESC_HI, 32'h0, st);
            `CHK("accessed", 32'h0000_9300, st)
        end
        bus(1'b0, 8'h18, 32'h0, st);
        `CHK("unmapped", 32'h0, st)
        `CHK("hresp", 1'b0, hresp)
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        `CHK("rst_mid_ready", 1'b0, hreadyout)
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        bus(1'b0, OFS_STATUS, 32'h0, st);
        `CHK("rst_mid_status", 32'h0, st)
        test_done();
    end
endmodule // tb_sdtc_top
